// file: logic/clkgen_pkg.sv
// Overview of operation
// - Prescaler code zero bypasses; codes 1-6 divide 2..64.
// - PLL source bit picks low or high range.
// - PLL source bit takes first write only.
// - Output source code picks slow, master, inverted, half.
// - Output disable bit releases clock output pin.
// - Mask bit zero reads PLL lock enable.
package clkgen_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFFSET = 8'h20;
  localparam logic [7:0] LOCK_MASK_OFFSET = 8'h3c;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] LOCK_MASK_RESET = 32'h0000_0000;
  // Bits 23:19 of the mode register are not implemented.
  localparam logic [31:0] MODE_WRITE_MASK = 32'hff07_ffff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PRESC_LSB = 0;
  localparam int PLL_SRC_BIT = 3;
  localparam int OUT_SRC_LSB = 4;
  localparam int OUT_DIS_BIT = 6;
  localparam int CLK_SRC_BIT = 7;
  localparam int MUL_LSB = 8;
  localparam int LOCK_COUNT_LSB = 24;
  localparam int LOCK_MASK_BIT = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PRESC_BYPASS = 3'h0;
  localparam logic [2:0] PRESC_DIV64 = 3'h6;
  localparam logic [2:0] PRESC_RESERVED = 3'h7;
  localparam logic PLL_LOW_RANGE = 1'b0;
  localparam logic PLL_HIGH_RANGE = 1'b1;
  localparam logic [1:0] OUT_SRC_SLOW = 2'h0;
  localparam logic [1:0] OUT_SRC_MASTER = 2'h1;
  localparam logic [1:0] OUT_SRC_MASTER_INV = 2'h2;
  localparam logic [1:0] OUT_SRC_MASTER_DIV2 = 2'h3;
  localparam int PRESC_CNT_W = 6;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lock_count;
    logic [4:0] unused;
    logic [10:0] multiplier;
    logic clk_src_sel;
    logic out_disable;
    logic [1:0] out_src;
    logic pll_src;
    logic [2:0] presc;
  } mode_fields_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// file: logic/clock_generator_mode_control.sv
`timescale 1ns/1ps
module clock_generator_mode_control (
  input wire logic clk,
  input wire logic rstn,
  input clkgen_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic slow_clk_in,
  input wire logic master_clk_in,
  input wire logic lock_irq_enable,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe_n,
  output logic prescaler_tick,
  output logic pll_high_range,
  output clkgen_pkg::mode_fields_t mode_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mask of counter bits that must all be set for a prescaler tick.
  // The reserved code falls back to bypass so the core never stalls.
  function automatic logic [5:0] presc_mask(input logic [2:0] sel);
    logic [5:0] m;
    m = 6'h00;
    case (sel)
      3'h1: m = 6'h01;
      3'h2: m = 6'h03;
      3'h3: m = 6'h07;
      3'h4: m = 6'h0f;
      3'h5: m = 6'h1f;
      3'h6: m = 6'h3f;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] mode_reg, mode_next;
  logic pll_src_taken_reg, pll_src_taken_next;
  logic lock_mask_reg, lock_mask_next;
  logic [31:0] rdata_reg, rdata_next;
  clkgen_pkg::mode_fields_t mode_f;
  logic mode_wr;
  clkgen_pkg::mode_fields_t wdata_f;

  // Field views of the mode register and of the write data; the second one only feeds the checks.
  assign mode_f = mode_reg;
  assign mode_wr = reg_req.wr && hit(reg_req.addr, clkgen_pkg::MODE_OFFSET);
  assign wdata_f = reg_req.wdata;

  // Write decode; the PLL source bit is frozen after the first write
  // because switching PLL range under a running core is unsafe.
  always_comb begin
    mode_next = mode_reg;
    pll_src_taken_next = pll_src_taken_reg;
    lock_mask_next = lock_irq_enable;
    if (mode_wr) begin
      mode_next = reg_req.wdata & clkgen_pkg::MODE_WRITE_MASK;
      if (pll_src_taken_reg) begin
        mode_next[clkgen_pkg::PLL_SRC_BIT] = mode_reg[clkgen_pkg::PLL_SRC_BIT];
      end
      pll_src_taken_next = 1'b1;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_req.rd) begin
      if (hit(reg_req.addr, clkgen_pkg::MODE_OFFSET)) begin
        rdata_next = mode_reg;
      end else if (hit(reg_req.addr, clkgen_pkg::LOCK_MASK_OFFSET)) begin
        rdata_next[clkgen_pkg::LOCK_MASK_BIT] = lock_mask_reg;
      end
    end
  end

  // Register stage for the register file.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= clkgen_pkg::MODE_RESET;
      pll_src_taken_reg <= 1'b0;
      lock_mask_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      mode_reg <= mode_next;
      pll_src_taken_reg <= pll_src_taken_next;
      lock_mask_reg <= lock_mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and PLL range
  // ----------------------------------------------------------------
  logic [5:0] presc_cnt_reg, presc_cnt_next;
  logic tick_reg, tick_next;
  logic pll_high_reg, pll_high_next;

  // A free running counter; a tick marks one cycle in every 2^code for codes 0-6, and every cycle for the reserved code.
  always_comb begin
    presc_cnt_next = presc_cnt_reg + 6'h01;
    tick_next = (presc_cnt_reg & presc_mask(mode_f.presc)) == presc_mask(mode_f.presc);
    pll_high_next = (mode_f.pll_src == clkgen_pkg::PLL_HIGH_RANGE);
  end

  // Register stage for the prescaler.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
      pll_high_reg <= 1'b0;
    end else begin
      presc_cnt_reg <= presc_cnt_next;
      tick_reg <= tick_next;
      pll_high_reg <= pll_high_next;
    end
  end

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  logic mclk_prev_reg, mclk_prev_next;
  logic half_reg, half_next;
  logic out_reg, out_next;
  logic oe_n_reg, oe_n_next;

  // The output is registered, so it lags the chosen source by one cycle;
  // the half rate copy toggles on each sampled rising edge of the master clock.
  always_comb begin
    mclk_prev_next = master_clk_in;
    half_next = half_reg ^ (master_clk_in && !mclk_prev_reg);
    case (mode_f.out_src)
      clkgen_pkg::OUT_SRC_SLOW: out_next = slow_clk_in;
      clkgen_pkg::OUT_SRC_MASTER: out_next = master_clk_in;
      clkgen_pkg::OUT_SRC_MASTER_INV: out_next = !master_clk_in;
      clkgen_pkg::OUT_SRC_MASTER_DIV2: out_next = half_reg;
      default: out_next = 1'b0;
    endcase
    oe_n_next = mode_f.out_disable;
  end

  // Register stage for the output pin; the pin is released during reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mclk_prev_reg <= 1'b0;
      half_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      mclk_prev_reg <= mclk_prev_next;
      half_reg <= half_next;
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign clock_out_pin_o = out_reg;
  assign clock_out_pin_oe_n = oe_n_reg;
  assign prescaler_tick = tick_reg;
  assign pll_high_range = pll_high_reg;
  assign mode_o = mode_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks other than a_presc_div2, a_pll_once, a_pll_first, a_mode_reserved and a_read_idle are gated by the sampled reset as well:
  // at the edge that releases reset the flops still load their reset values, so that edge must not be judged against the register contents.
  a_presc_bypass: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.presc == 3'h0 && $past(mode_f.presc) == 3'h0) |=> tick_reg
  ) else $error("Prescaler bypass did not tick every cycle.");

  a_presc_reserved: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.presc == clkgen_pkg::PRESC_RESERVED) |=> tick_reg
  ) else $error("Reserved prescaler code did not behave as bypass.");

  a_presc_div64_hit: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.presc == clkgen_pkg::PRESC_DIV64 && presc_cnt_reg == 6'h3f) |=> tick_reg
  ) else $error("Divide by sixty-four prescaler missed its tick.");

  a_presc_div64_gap: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.presc == clkgen_pkg::PRESC_DIV64 && presc_cnt_reg != 6'h3f) |=> !tick_reg
  ) else $error("Divide by sixty-four prescaler ticked too early.");

  a_presc_count: assert property (
    @(posedge clk) disable iff (!rstn)
    rstn |=> presc_cnt_reg == $past(presc_cnt_reg) + 6'h01
  ) else $error("Prescaler counter did not advance by one.");

  a_presc_div2: assert property (
    @(posedge clk) disable iff (!rstn)
    (tick_reg && mode_f.presc == 3'h1 && $past(mode_f.presc) == 3'h1 && !mode_wr) |=> (!tick_reg ##1 tick_reg)
  ) else $error("Divide by two prescaler spacing wrong.");

  a_pll_range: assert property (
    @(posedge clk) disable iff (!rstn)
    rstn |=> pll_high_reg == $past(mode_f.pll_src)
  ) else $error("PLL range does not follow the source bit.");

  a_pll_low: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.pll_src == clkgen_pkg::PLL_LOW_RANGE) |=> !pll_high_range
  ) else $error("Low range PLL not selected for a cleared source bit.");

  a_pll_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && !mode_wr) |=> $stable(mode_f.pll_src)
  ) else $error("PLL source bit changed without a mode write.");

  a_pll_once: assert property (
    @(posedge clk) disable iff (!rstn)
    (pll_src_taken_reg && mode_wr) |=> $stable(mode_f.pll_src)
  ) else $error("PLL source bit changed after first write.");

  a_pll_first: assert property (
    @(posedge clk) disable iff (!rstn)
    (!pll_src_taken_reg && mode_wr) |=> mode_f.pll_src == $past(wdata_f.pll_src)
  ) else $error("First write did not set the PLL source bit.");

  a_out_master: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.out_src == clkgen_pkg::OUT_SRC_MASTER) |=> clock_out_pin_o == $past(master_clk_in)
  ) else $error("Clock output does not follow master clock.");

  a_out_inverted: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.out_src == clkgen_pkg::OUT_SRC_MASTER_INV) |=> clock_out_pin_o != $past(master_clk_in)
  ) else $error("Clock output is not the inverted master clock.");

  a_out_slow: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.out_src == clkgen_pkg::OUT_SRC_SLOW) |=> clock_out_pin_o == $past(slow_clk_in)
  ) else $error("Clock output does not follow slow clock.");

  a_out_half: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_f.out_src == clkgen_pkg::OUT_SRC_MASTER_DIV2) |=> clock_out_pin_o == $past(half_reg)
  ) else $error("Clock output does not follow the halved master clock.");

  a_half_toggle: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && master_clk_in && !mclk_prev_reg) |=> half_reg != $past(half_reg)
  ) else $error("Halved clock missed a master clock rising edge.");

  a_half_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && !(master_clk_in && !mclk_prev_reg)) |=> $stable(half_reg)
  ) else $error("Halved clock toggled without a master clock rising edge.");

  a_out_release: assert property (
    @(posedge clk) disable iff (!rstn)
    rstn |=> clock_out_pin_oe_n == $past(mode_f.out_disable)
  ) else $error("Clock output enable does not follow disable bit.");

  a_mask_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && reg_req.rd && hit(reg_req.addr, clkgen_pkg::LOCK_MASK_OFFSET))
      |=> reg_rdata == {31'h0, $past(lock_mask_reg)}
  ) else $error("Lock mask read returned wrong value.");

  a_mask_follow: assert property (
    @(posedge clk) disable iff (!rstn)
    rstn |=> lock_mask_reg == $past(lock_irq_enable)
  ) else $error("Lock mask bit does not follow the interrupt enable.");

  a_mode_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && reg_req.rd && hit(reg_req.addr, clkgen_pkg::MODE_OFFSET))
      |=> (reg_rdata == $past(mode_reg) && reg_rdata[23:19] == 5'h00)
  ) else $error("Mode read returned wrong value.");

  a_mode_write: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && mode_wr) |=> (mode_o.lock_count == $past(wdata_f.lock_count)
      && mode_o.multiplier == $past(wdata_f.multiplier) && mode_o.presc == $past(wdata_f.presc)
      && mode_o.out_src == $past(wdata_f.out_src) && mode_o.out_disable == $past(wdata_f.out_disable)
      && mode_o.clk_src_sel == $past(wdata_f.clk_src_sel))
  ) else $error("Mode write did not land in its fields.");

  a_mode_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && !mode_wr) |=> $stable(mode_reg)
  ) else $error("Mode register changed without a mode write.");

  a_mode_reserved: assert property (
    @(posedge clk) disable iff (!rstn)
    mode_o.unused == 5'h00
  ) else $error("Unimplemented mode bits are not zero.");

  a_unmapped_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (rstn && reg_req.rd && !hit(reg_req.addr, clkgen_pkg::MODE_OFFSET)
      && !hit(reg_req.addr, clkgen_pkg::LOCK_MASK_OFFSET)) |=> reg_rdata == 32'h0
  ) else $error("Unmapped read returned nonzero data.");

  a_read_idle: assert property (
    @(posedge clk) disable iff (!rstn)
    !reg_req.rd |=> reg_rdata == 32'h0
  ) else $error("Read data not zero outside a read.");

endmodule

// file: test/clock_generator_mode_control_tb.sv
`timescale 1ns/1ps
module clock_generator_mode_control_tb;
  logic clk;
  logic rstn;
  clkgen_pkg::reg_req_t req;
  logic [31:0] rdata;
  logic lock_en;
  logic [3:0] ph = 4'h0;
  logic m_d;
  logic s_d;
  logic pin_o;
  logic oe_n;
  logic tick;
  logic high;
  logic level;
  clkgen_pkg::mode_fields_t mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cnt;
  logic prev;

  // ----------------------------------------------------------------
  // Clock, sources and device
  // ----------------------------------------------------------------
  // The master reference has a four-cycle period and the slow clock sixteen, so both have visible edges.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    ph <= ph + 4'h1;
    m_d <= ph[1];
    s_d <= ph[3];
  end

  clock_generator_mode_control i_dut (.clk(clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
    .slow_clk_in(ph[3]), .master_clk_in(ph[1]), .lock_irq_enable(lock_en), .clock_out_pin_o(pin_o),
    .clock_out_pin_oe_n(oe_n), .prescaler_tick(tick), .pll_high_range(high), .mode_o(mode));
  clock_out_receiver i_rx (.clk(clk), .pin_o(pin_o), .pin_oe_n(oe_n), .pin_level(level));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // The span covers every test several times over; a hang ends the run as a failure.
  initial begin
    #(40 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    req = '0;
    lock_en = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(clkgen_pkg::MODE_OFFSET, 32'h0000_0000);
    rd(clkgen_pkg::LOCK_MASK_OFFSET, 32'h0000_0000);
    wr(clkgen_pkg::MODE_OFFSET, 32'hffff_ffff);
    @(negedge clk);
    chk(mode, 32'hff07_ffff);
    // The range output is registered from the mode register, one cycle behind it.
    @(negedge clk);
    chk({31'h0, high}, 32'h0000_0001);
    rd(clkgen_pkg::MODE_OFFSET, 32'hff07_ffff);
    wr(clkgen_pkg::MODE_OFFSET, 32'h0000_0000);
    rd(clkgen_pkg::MODE_OFFSET, 32'h0000_0008);
    chk({31'h0, high}, 32'h0000_0001);
    rd(8'h44, 32'h0000_0000);
    wr(clkgen_pkg::LOCK_MASK_OFFSET, 32'hffff_ffff);
    rd(clkgen_pkg::LOCK_MASK_OFFSET, 32'h0000_0000);
    @(posedge clk);
    lock_en <= 1'b1;
    rd(clkgen_pkg::LOCK_MASK_OFFSET, 32'h0000_0001);
    // Any 64-cycle window holds exactly 64 >> code ticks; the reserved code acts as bypass.
    for (int c = 0; c < 8; c++) begin
      wr(clkgen_pkg::MODE_OFFSET, 32'(c));
      repeat (2) @(posedge clk);
      cnt = 0;
      repeat (64) begin
        @(negedge clk);
        cnt += tick;
      end
      chk(32'(cnt), (c == 7) ? 32'd64 : 32'd64 >> c);
    end
    // The pin follows the selected source one cycle late; the halved clock is judged by its toggles.
    for (int s = 0; s < 4; s++) begin
      wr(clkgen_pkg::MODE_OFFSET, 32'(s) << clkgen_pkg::OUT_SRC_LSB);
      repeat (2) @(posedge clk);
      @(negedge clk);
      prev = level;
      cnt = 0;
      for (int k = 0; k < 32; k++) begin
        @(negedge clk);
        if (s < 3) chk({31'h0, level}, {31'h0, (s == 0) ? s_d : (s == 1) ? m_d : ~m_d});
        if (level != prev) cnt++;
        prev = level;
      end
      if (s == 3) chk(32'(cnt), 32'd8);
    end
    chk({31'h0, oe_n}, 32'h0000_0000);
    wr(clkgen_pkg::MODE_OFFSET, 32'h0000_0050);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({31'h0, oe_n}, 32'h0000_0001);
    // A second reset reopens the one-time PLL source write; this time the first write keeps it low.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(clkgen_pkg::MODE_OFFSET, 32'h0000_0000);
    wr(clkgen_pkg::MODE_OFFSET, 32'h0000_0000);
    wr(clkgen_pkg::MODE_OFFSET, 32'h0000_0008);
    rd(clkgen_pkg::MODE_OFFSET, 32'h0000_0000);
    chk({31'h0, high}, 32'h0000_0000);
    final_report();
  end
endmodule

// file: test/clock_out_receiver.sv
`timescale 1ns/1ps
module clock_out_receiver (
  input wire logic clk,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_level
);
  logic last_level = 1'b0;

  // The board has no keeper on this net, so a released pin drifts away from its last driven level.
  always_ff @(posedge clk) begin
    if (!pin_oe_n) begin
      last_level <= pin_o;
    end
  end
  assign pin_level = pin_oe_n ? ~last_level : pin_o;
endmodule
